// *** rtl/uhf_defines.svh ***
// register map, field positions, reset values and timing counts of the serial port
`ifndef UHF_DEFINES_SVH
`define UHF_DEFINES_SVH
`define UHF_ADDR_CTRL 8'h00
`define UHF_ADDR_BAUD 8'h04
`define UHF_ADDR_TXDATA 8'h08
`define UHF_ADDR_RXDATA 8'h0C
`define UHF_ADDR_STATUS 8'h10
`define UHF_ADDR_INTSTAT 8'h14
`define UHF_ADDR_INTMASK 8'h18
`define UHF_CTRL_EN 0
`define UHF_CTRL_PAR_EN 1
`define UHF_CTRL_PAR_ODD 2
`define UHF_CTRL_RTS_HOLD 3
`define UHF_CTRL_RST 4'h0
`define UHF_BAUD_RST 16'h087A
`define UHF_INT_RX 0
`define UHF_INT_TX 1
`define UHF_INT_PERR 2
`define UHF_INT_FERR 3
`define UHF_INT_OVR 4
`define UHF_INT_CTS 5
`define UHF_INT_W 6
`define UHF_INT_RST 6'h00
`define UHF_CLK_NS 4
`define UHF_MIN_BIT_NS 1000
`define UHF_DIV_MIN ((`UHF_MIN_BIT_NS + `UHF_CLK_NS - 1) / `UHF_CLK_NS)
`define UHF_RESP_OKAY 2'h0
`define UHF_RESP_SLVERR 2'h2
`endif

// *** rtl/uhf_pkg.sv ***
// types shared by the serial port design
package uhf_pkg;
  typedef enum logic [2:0]
  {
    UHF_IDLE = 3'h0,
    UHF_START = 3'h1,
    UHF_DATA = 3'h2,
    UHF_PAR = 3'h3,
    UHF_STOP = 3'h4
  } uhf_frame_t;
endpackage

// *** rtl/uhf_sync.sv ***
// two-flop synchroniser for one asynchronous pin
`timescale 1ns/100ps
module uhf_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_r;

  // meta_r feeds only the second flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// *** rtl/uhf_top.sv ***
// serial port with rts/cts handshake, parity on a ninth bit and an axi4-lite register slave
//
// Notes on behaviour
// - transmit and receive run independently at once, up to one megabit per second
// - with parity on, send a ninth parity bit and check it on every character
// - rts is an output, cts an input, both active low
// - each data output rests high while no character is sent
// - low on a handshake line means asserted, high means deasserted
// - once configured, transmit pin is driven as an output, high by default
// - receive pin has a pull-up so an open line reads idle
// - once configured, rts is driven low, meaning ready to receive
// - cts pin has a pull-down so an open line permits sending
// - framing and handshake match a conventional uart peer
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "uhf_defines.svh"
module uhf_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ,
  output logic PORT_PIN_SIX,
  output logic PORT_PIN_SIX_OE,
  input wire logic PORT_PIN_EIGHT,
  output logic PORT_PIN_EIGHT_PU,
  output logic PORT_PIN_FIVE_N,
  output logic PORT_PIN_FIVE_OE,
  input wire logic PORT_PIN_SEVEN_N,
  output logic PORT_PIN_SEVEN_PD
);
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r, irq_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r, rd_data;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r, rd_resp;
  logic [3:0] ctrl_r;
  logic [15:0] baud_r, div_eff;
  logic [`UHF_INT_W-1:0] int_stat_r, int_mask_r, ev, int_clr;
  logic txh_valid_r, rxh_valid_r;
  logic [7:0] txh_data_r;
  logic [10:0] rxh_data_r;
  logic rx_s, cts_n_s, cts_d_r;
  logic tx_line_r, tx_oe_r, rts_n_r, pull_r, tx_par_r, rx_par_r;
  uhf_pkg::uhf_frame_t tx_state_r, rx_state_r;
  logic [15:0] tx_cnt_r, rx_cnt_r;
  logic [2:0] tx_bit_r, rx_bit_r;
  logic [7:0] tx_sh_r, rx_sh_r;
  logic wr_fire, wr_ok, ar_fire, rd_pop, tx_go, tx_fin, rx_fin, perr_c, ferr_c;
  logic ctrl_en, par_en, par_odd;

  assign ctrl_en = ctrl_r[`UHF_CTRL_EN];
  assign par_en = ctrl_r[`UHF_CTRL_PAR_EN];
  assign par_odd = ctrl_r[`UHF_CTRL_PAR_ODD];

  // both pins cross from outside; cts resets asserted as the pull-down would read
  uhf_sync #(.RST_VAL(1'b1)) rx_sync (.clk(CLK), .rst(RST), .d(PORT_PIN_EIGHT), .q(rx_s));
  uhf_sync #(.RST_VAL(1'b0)) cts_sync (.clk(CLK), .rst(RST), .d(PORT_PIN_SEVEN_N), .q(cts_n_s));

  // bit time never drops below the one megabit limit, whatever software writes
  assign div_eff = (baud_r < 16'(`UHF_DIV_MIN)) ? 16'(`UHF_DIV_MIN) : baud_r;

  // write channel: address and data are caught independently, in either order
  assign S_AXI_AWREADY = !aw_hold_r && !bvalid_r;
  assign S_AXI_WREADY = !w_hold_r && !bvalid_r;
  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bresp_r <= `UHF_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      else if (wr_fire)
        aw_hold_r <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      else if (wr_fire)
        w_hold_r <= 1'b0;
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `UHF_RESP_OKAY : `UHF_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
        bvalid_r <= 1'b0;
    end
  end

  // status and rx data are read-only, so writes to them answer slverr
  always_comb
  begin
    if (aw_addr_r == `UHF_ADDR_CTRL || aw_addr_r == `UHF_ADDR_BAUD)
      wr_ok = 1'b1;
    else if (aw_addr_r == `UHF_ADDR_TXDATA || aw_addr_r == `UHF_ADDR_INTSTAT)
      wr_ok = 1'b1;
    else if (aw_addr_r == `UHF_ADDR_INTMASK)
      wr_ok = 1'b1;
    else
      wr_ok = 1'b0;
  end

  // configuration registers, byte lane 0 except the upper baud byte on lane 1
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_r <= `UHF_CTRL_RST;
      baud_r <= `UHF_BAUD_RST;
      int_mask_r <= `UHF_INT_RST;
    end
    else if (wr_fire)
    begin
      if (aw_addr_r == `UHF_ADDR_CTRL && w_strb_r[0])
        ctrl_r <= w_data_r[3:0];
      if (aw_addr_r == `UHF_ADDR_BAUD && w_strb_r[0])
        baud_r[7:0] <= w_data_r[7:0];
      if (aw_addr_r == `UHF_ADDR_BAUD && w_strb_r[1])
        baud_r[15:8] <= w_data_r[15:8];
      if (aw_addr_r == `UHF_ADDR_INTMASK && w_strb_r[0])
        int_mask_r <= w_data_r[`UHF_INT_W-1:0];
    end
  end

  // read channel: one cycle from address to data
  assign ar_fire = S_AXI_ARVALID && !rvalid_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign rd_pop = ar_fire && S_AXI_ARADDR == `UHF_ADDR_RXDATA;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  always_comb
  begin
    rd_data = 32'h00000000;
    rd_resp = `UHF_RESP_OKAY;
    if (S_AXI_ARADDR == `UHF_ADDR_CTRL)
      rd_data[3:0] = ctrl_r;
    else if (S_AXI_ARADDR == `UHF_ADDR_BAUD)
      rd_data[15:0] = baud_r;
    else if (S_AXI_ARADDR == `UHF_ADDR_TXDATA)
      rd_data[7:0] = txh_data_r;
    else if (S_AXI_ARADDR == `UHF_ADDR_RXDATA)
      rd_data[10:0] = rxh_data_r;
    else if (S_AXI_ARADDR == `UHF_ADDR_STATUS)
      rd_data[4:0] = {~rts_n_r, ~cts_n_s, rxh_valid_r, txh_valid_r,
                      tx_state_r != uhf_pkg::UHF_IDLE};
    else if (S_AXI_ARADDR == `UHF_ADDR_INTSTAT)
      rd_data[`UHF_INT_W-1:0] = int_stat_r;
    else if (S_AXI_ARADDR == `UHF_ADDR_INTMASK)
      rd_data[`UHF_INT_W-1:0] = int_mask_r;
    else
      rd_resp = `UHF_RESP_SLVERR;
  end
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `UHF_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_resp;
    end
    else if (S_AXI_RREADY)
      rvalid_r <= 1'b0;
  end

  // one-character transmit holding register; a write while full is dropped
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      txh_valid_r <= 1'b0;
      txh_data_r <= 8'h00;
    end
    else if (tx_go)
      txh_valid_r <= 1'b0;
    else if (wr_fire && aw_addr_r == `UHF_ADDR_TXDATA && w_strb_r[0] && !txh_valid_r)
    begin
      txh_valid_r <= 1'b1;
      txh_data_r <= w_data_r[7:0];
    end
  end

  // a character only starts while cts is low; once started it always completes
  assign tx_go = tx_state_r == uhf_pkg::UHF_IDLE && txh_valid_r && ctrl_en
                 && !cts_n_s;
  assign tx_fin = tx_state_r == uhf_pkg::UHF_STOP && tx_cnt_r == 16'h0000;

  // transmitter: start, eight data bits lsb first, optional parity, one stop
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_state_r <= uhf_pkg::UHF_IDLE;
      tx_line_r <= 1'b1;
      tx_cnt_r <= 16'h0000;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
    end
    else if (tx_state_r == uhf_pkg::UHF_IDLE)
    begin
      tx_line_r <= !tx_go;
      if (tx_go)
      begin
        tx_sh_r <= txh_data_r;
        tx_par_r <= (^txh_data_r) ^ par_odd;
        tx_cnt_r <= div_eff - 16'h0001;
        tx_state_r <= uhf_pkg::UHF_START;
      end
    end
    else if (tx_cnt_r != 16'h0000)
      tx_cnt_r <= tx_cnt_r - 16'h0001;
    else
    begin
      tx_cnt_r <= div_eff - 16'h0001;
      case (tx_state_r)
        uhf_pkg::UHF_START:
        begin
          tx_line_r <= tx_sh_r[0];
          tx_sh_r <= {1'b0, tx_sh_r[7:1]};
          tx_bit_r <= 3'h0;
          tx_state_r <= uhf_pkg::UHF_DATA;
        end
        uhf_pkg::UHF_DATA:
        begin
          if (tx_bit_r == 3'h7)
          begin
            tx_line_r <= par_en ? tx_par_r : 1'b1;
            tx_state_r <= par_en ? uhf_pkg::UHF_PAR : uhf_pkg::UHF_STOP;
          end
          else
          begin
            tx_line_r <= tx_sh_r[0];
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
          end
        end
        uhf_pkg::UHF_PAR:
        begin
          tx_line_r <= 1'b1;
          tx_state_r <= uhf_pkg::UHF_STOP;
        end
        default:
        begin
          tx_line_r <= 1'b1;
          tx_state_r <= uhf_pkg::UHF_IDLE;
        end
      endcase
    end
  end

  // receiver samples mid-bit; a start that is high again at mid-bit was a glitch
  assign rx_fin = rx_state_r == uhf_pkg::UHF_STOP && rx_cnt_r == 16'h0000;
  assign perr_c = par_en && (rx_par_r != ((^rx_sh_r) ^ par_odd));
  assign ferr_c = !rx_s;
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_state_r <= uhf_pkg::UHF_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
    end
    else if (rx_state_r == uhf_pkg::UHF_IDLE)
    begin
      if (ctrl_en && !rx_s)
      begin
        rx_cnt_r <= {1'b0, div_eff[15:1]};
        rx_state_r <= uhf_pkg::UHF_START;
      end
    end
    else if (rx_cnt_r != 16'h0000)
      rx_cnt_r <= rx_cnt_r - 16'h0001;
    else
    begin
      rx_cnt_r <= div_eff - 16'h0001;
      case (rx_state_r)
        uhf_pkg::UHF_START:
        begin
          rx_bit_r <= 3'h0;
          rx_state_r <= rx_s ? uhf_pkg::UHF_IDLE : uhf_pkg::UHF_DATA;
        end
        uhf_pkg::UHF_DATA:
        begin
          rx_sh_r <= {rx_s, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 3'h1;
          if (rx_bit_r == 3'h7)
            rx_state_r <= par_en ? uhf_pkg::UHF_PAR : uhf_pkg::UHF_STOP;
        end
        uhf_pkg::UHF_PAR:
        begin
          rx_par_r <= rx_s;
          rx_state_r <= uhf_pkg::UHF_STOP;
        end
        default:
          rx_state_r <= uhf_pkg::UHF_IDLE;
      endcase
    end
  end

  // one-character receive holding register; the old character wins on overrun
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rxh_valid_r <= 1'b0;
      rxh_data_r <= 11'h000;
    end
    else if (rx_fin && (!rxh_valid_r || rd_pop))
    begin
      rxh_valid_r <= 1'b1;
      rxh_data_r <= {ferr_c, perr_c, par_en & rx_par_r, rx_sh_r};
    end
    else if (rd_pop)
      rxh_valid_r <= 1'b0;
  end

  // pin drive; rts is deasserted (pin high) while the holding register is full, as nothing else buffers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_oe_r <= 1'b0;
      pull_r <= 1'b0;
      rts_n_r <= 1'b1;
      cts_d_r <= 1'b0;
    end
    else
    begin
      tx_oe_r <= ctrl_en;
      pull_r <= ctrl_en;
      rts_n_r <= !ctrl_en || rxh_valid_r || ctrl_r[`UHF_CTRL_RTS_HOLD];
      cts_d_r <= cts_n_s;
    end
  end
  assign PORT_PIN_SIX = tx_line_r;
  assign PORT_PIN_SIX_OE = tx_oe_r;
  assign PORT_PIN_EIGHT_PU = pull_r;
  assign PORT_PIN_SEVEN_PD = pull_r;
  assign PORT_PIN_FIVE_N = rts_n_r;
  assign PORT_PIN_FIVE_OE = tx_oe_r;

  // sticky events; a new event in the clearing cycle survives the clear
  assign ev[`UHF_INT_RX] = rx_fin;
  assign ev[`UHF_INT_TX] = tx_fin;
  assign ev[`UHF_INT_PERR] = rx_fin && perr_c;
  assign ev[`UHF_INT_FERR] = rx_fin && ferr_c;
  assign ev[`UHF_INT_OVR] = rx_fin && rxh_valid_r && !rd_pop;
  assign ev[`UHF_INT_CTS] = cts_d_r != cts_n_s;
  assign int_clr = (wr_fire && aw_addr_r == `UHF_ADDR_INTSTAT && w_strb_r[0])
                   ? w_data_r[`UHF_INT_W-1:0] : `UHF_INT_RST;
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      int_stat_r <= `UHF_INT_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      int_stat_r <= (int_stat_r & ~int_clr) | ev;
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end
  assign IRQ = irq_r;

  // checks on the behaviour above
  tx_idle_high_a: assert property (
    @(posedge CLK) disable iff (RST)
    (tx_state_r == uhf_pkg::UHF_IDLE && !$past(tx_go)) |-> PORT_PIN_SIX)
    else $error("transmit line not idle high");
  tx_cts_start_a: assert property (
    @(posedge CLK) disable iff (RST)
    (tx_state_r == uhf_pkg::UHF_START && $past(tx_state_r) == uhf_pkg::UHF_IDLE)
    |-> !$past(cts_n_s))
    else $error("character started while cts deasserted");
  start_bit_low_a: assert property (
    @(posedge CLK) disable iff (RST)
    tx_go |=> !PORT_PIN_SIX [*2])
    else $error("start bit not low");
  parity_bit_a: assert property (
    @(posedge CLK) disable iff (RST)
    (tx_state_r == uhf_pkg::UHF_PAR) |-> (PORT_PIN_SIX == ((^txh_data_r) ^ par_odd)
      || txh_valid_r || $past(txh_valid_r, 2)) && par_en)
    else $error("parity bit wrong");
  bit_time_a: assert property (
    @(posedge CLK) disable iff (RST)
    tx_cnt_r < div_eff && div_eff >= 16'(`UHF_DIV_MIN))
    else $error("bit time shorter than allowed");
  rts_full_a: assert property (
    @(posedge CLK) disable iff (RST)
    rx_fin && ctrl_en |=> ##1 PORT_PIN_FIVE_N)
    else $error("rts not deasserted with full holding register");
  rts_ready_a: assert property (
    @(posedge CLK) disable iff (RST)
    (ctrl_en && !rxh_valid_r && !ctrl_r[`UHF_CTRL_RTS_HOLD]) [*2] |-> !PORT_PIN_FIVE_N)
    else $error("rts not asserted while ready");
  tx_drive_a: assert property (
    @(posedge CLK) disable iff (RST)
    $rose(ctrl_en) |=> PORT_PIN_SIX_OE && PORT_PIN_FIVE_OE)
    else $error("pins not driven after enable");
  rx_pull_a: assert property (
    @(posedge CLK) disable iff (RST)
    ctrl_en |=> PORT_PIN_EIGHT_PU)
    else $error("receive pull-up missing");
  cts_pull_a: assert property (
    @(posedge CLK) disable iff (RST)
    $fell(ctrl_en) |=> !PORT_PIN_SEVEN_PD)
    else $error("cts pull-down not following enable");
  perr_flag_a: assert property (
    @(posedge CLK) disable iff (RST)
    (rx_fin && perr_c) |=> int_stat_r[`UHF_INT_PERR])
    else $error("parity error not flagged");
endmodule

// *** tb/uhf_peer.sv ***
// far-end serial peer: drives the receive and cts pins, decodes the transmit pin
`timescale 1ns/100ps
module uhf_peer #(
  parameter int BIT = 250
) (
  input wire logic clk,
  input wire logic rx_line,
  input wire logic rts_n,
  output logic tx_line,
  output logic cts_n
);
  logic [9:0] got_q[$];
  logic [9:0] sh;
  int nbits = 8;

  // both lines start idle, cts asserted
  initial
  begin
    tx_line = 1'h1;
    cts_n = 1'h0;
  end

  // handshake line towards the device, changed just after a clock edge
  task automatic set_cts(input logic v);
    cts_n <= v;
  endtask

  // one frame out, lsb first; waits while the device holds rts deasserted
  task automatic send(input logic [8:0] d, input int n);
    while (rts_n !== 1'h0)
      @(posedge clk);
    tx_line <= 1'h0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      tx_line <= d[i];
      repeat (BIT) @(posedge clk);
    end
    tx_line <= 1'h1;
    repeat (BIT) @(posedge clk);
  endtask

  // samples mid-bit; the stop bit lands in bit nbits, just above the last data or parity bit
  always
  begin
    @(posedge clk iff rx_line === 1'h0);
    sh = 10'h3FF;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i <= nbits; i++)
    begin
      repeat (BIT) @(posedge clk);
      sh[i] = rx_line;
    end
    got_q.push_back(sh);
  end
endmodule

// *** tb/uhf_top_test.sv ***
// self-checking bench for the serial port with handshake
`timescale 1ns/100ps
`include "uhf_defines.svh"
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module uhf_top_test;
  logic CLK = 1'h0, RST = 1'h1;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdata;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
  logic PORT_PIN_SIX, PORT_PIN_SIX_OE, PORT_PIN_EIGHT, PORT_PIN_EIGHT_PU;
  logic PORT_PIN_FIVE_N, PORT_PIN_FIVE_OE, PORT_PIN_SEVEN_N, PORT_PIN_SEVEN_PD;
  logic tx_wire, rts_wire;
  int mismatches = 0, tests_run = 0;

  always #2 CLK = ~CLK;
  // an undriven pin is seen through the peer's own pull-up
  assign tx_wire = PORT_PIN_SIX_OE ? PORT_PIN_SIX : 1'h1;
  assign rts_wire = PORT_PIN_FIVE_OE ? PORT_PIN_FIVE_N : 1'h1;

  uhf_top uhf_top_inst (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ), .PORT_PIN_SIX(PORT_PIN_SIX),
    .PORT_PIN_SIX_OE(PORT_PIN_SIX_OE), .PORT_PIN_EIGHT(PORT_PIN_EIGHT),
    .PORT_PIN_EIGHT_PU(PORT_PIN_EIGHT_PU), .PORT_PIN_FIVE_N(PORT_PIN_FIVE_N),
    .PORT_PIN_FIVE_OE(PORT_PIN_FIVE_OE), .PORT_PIN_SEVEN_N(PORT_PIN_SEVEN_N),
    .PORT_PIN_SEVEN_PD(PORT_PIN_SEVEN_PD));

  uhf_peer uhf_peer_inst (.clk(CLK), .rx_line(tx_wire), .rts_n(rts_wire),
    .tx_line(PORT_PIN_EIGHT), .cts_n(PORT_PIN_SEVEN_N));

  // address and data offered together, each dropped at its own ready
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    while (aw || w)
    begin
      @(posedge CLK);
      if (aw && S_AXI_AWREADY === 1'h1)
      begin
        aw = 1'h0;
        S_AXI_AWVALID <= 1'h0;
      end
      if (w && S_AXI_WREADY === 1'h1)
      begin
        w = 1'h0;
        S_AXI_WVALID <= 1'h0;
      end
    end
    do @(posedge CLK); while (S_AXI_BVALID !== 1'h1);
    resp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'h0;
    @(posedge CLK);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    do @(posedge CLK); while (S_AXI_ARREADY !== 1'h1);
    S_AXI_ARVALID <= 1'h0;
    do @(posedge CLK); while (S_AXI_RVALID !== 1'h1);
    resp = S_AXI_RRESP;
    rdata = S_AXI_RDATA;
    S_AXI_RREADY <= 1'h0;
    @(posedge CLK);
  endtask

  // bounded wait for the peer to decode one frame
  task automatic tx_expect(input logic [9:0] e);
    logic [9:0] g;
    repeat (4000) if (uhf_peer_inst.got_q.size() == 0) @(posedge CLK);
    if (uhf_peer_inst.got_q.size() != 0) g = uhf_peer_inst.got_q.pop_front();
    `CHK(g, e)
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // sized for about two dozen frames of 250-cycle bits
  initial
  begin
    repeat (60000) @(posedge CLK);
    mismatches++;
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge CLK);
    RST <= 1'h0;
    @(posedge CLK);
    `CHK({PORT_PIN_SIX, PORT_PIN_SIX_OE, PORT_PIN_FIVE_N}, 3'h5)
    axi_rd(`UHF_ADDR_BAUD);
    `CHK(rdata[15:0], 16'h087A)
    axi_rd(8'h40);
    `CHK(resp, 2'h2)
    axi_wr(`UHF_ADDR_STATUS, 32'h1);
    `CHK(resp, 2'h2)
    // shortest bit time, then enable
    axi_wr(`UHF_ADDR_BAUD, 32'hFA);
    axi_wr(`UHF_ADDR_CTRL, 32'h1);
    `CHK({PORT_PIN_SIX_OE, PORT_PIN_SIX}, 2'h3)
    `CHK({PORT_PIN_FIVE_OE, PORT_PIN_FIVE_N}, 2'h2)
    `CHK(PORT_PIN_EIGHT_PU, 1'h1)
    `CHK(PORT_PIN_SEVEN_PD, 1'h1)
    // both directions at once, receive interrupt unmasked
    axi_wr(`UHF_ADDR_INTMASK, 32'h1 << `UHF_INT_RX);
    fork
      axi_wr(`UHF_ADDR_TXDATA, 32'hA5);
      uhf_peer_inst.send(9'h03C, 8);
    join
    tx_expect({2'h3, 8'hA5});
    repeat (4) @(posedge CLK);
    `CHK({IRQ, PORT_PIN_FIVE_N}, 2'h3)
    axi_rd(`UHF_ADDR_RXDATA);
    `CHK(rdata[7:0], 8'h3C)
    repeat (3) @(posedge CLK);
    `CHK(PORT_PIN_FIVE_N, 1'h0)
    axi_rd(`UHF_ADDR_INTSTAT);
    `CHK(rdata[1:0], 2'h3)
    axi_wr(`UHF_ADDR_INTSTAT, 32'h3F);
    axi_rd(`UHF_ADDR_INTSTAT);
    `CHK({IRQ, rdata[5:0]}, 7'h00)
    // even then odd; the peer sends 0x5A with parity 0, right for even only
    uhf_peer_inst.nbits = 9;
    for (int m = 0; m < 2; m++)
    begin
      axi_wr(`UHF_ADDR_CTRL, {29'h0, m[0], 2'h3});
      fork
        axi_wr(`UHF_ADDR_TXDATA, 32'h07);
        uhf_peer_inst.send(9'h05A, 9);
      join
      tx_expect({1'h1, ~m[0], 8'h07});
      repeat (4) @(posedge CLK);
      axi_rd(`UHF_ADDR_RXDATA);
      `CHK(rdata[9:0], {m[0], 9'h05A})
      axi_rd(`UHF_ADDR_INTSTAT);
      `CHK(rdata[`UHF_INT_PERR], m[0])
      axi_wr(`UHF_ADDR_INTSTAT, 32'h3F);
    end
    // cts withdrawn mid-character: that one finishes, the next waits
    uhf_peer_inst.nbits = 8;
    axi_wr(`UHF_ADDR_CTRL, 32'h1);
    axi_wr(`UHF_ADDR_TXDATA, 32'h55);
    repeat (100) if (PORT_PIN_SIX !== 1'h0) @(posedge CLK);
    uhf_peer_inst.set_cts(1'h1);
    axi_wr(`UHF_ADDR_TXDATA, 32'h66);
    tx_expect({2'h3, 8'h55});
    repeat (3000) @(posedge CLK);
    `CHK({uhf_peer_inst.got_q.size() == 0, PORT_PIN_SIX}, 2'h3)
    uhf_peer_inst.set_cts(1'h0);
    tx_expect({2'h3, 8'h66});
    // let the stop bit finish, then the cts toggles must have left their mark
    repeat (200) @(posedge CLK);
    axi_rd(`UHF_ADDR_INTSTAT);
    `CHK(rdata[`UHF_INT_CTS], 1'h1)
    // forced rts deassert, seen on the pin and in the status word
    axi_wr(`UHF_ADDR_CTRL, 32'h9);
    repeat (2) @(posedge CLK);
    `CHK(PORT_PIN_FIVE_N, 1'h1)
    axi_rd(`UHF_ADDR_STATUS);
    `CHK(rdata[4:0], 5'h08)
    // disabled again: pins released and pulls off
    axi_wr(`UHF_ADDR_CTRL, 32'h0);
    `CHK({PORT_PIN_SIX_OE, PORT_PIN_FIVE_OE}, 2'h0)
    `CHK({PORT_PIN_EIGHT_PU, PORT_PIN_SEVEN_PD}, 2'h0)
    summarize();
  end
endmodule
